/* src/pftb_pkg.sv */
/*
 * Shared constants and types of the program-flow trace recorder:
 * register offsets, field positions, reset values, trace and packet
 * carriers. Assumes a 32-bit APB register bus and 32-bit trace words.
 */
package pftb_pkg;

  // register window of the recorder in the system map
  localparam logic [31:0] REG_BASE_ADDR    = 32'h4100_6000;
  localparam int          REG_WIN_LSB      = 12;

  localparam logic [11:0] OFF_POSITION     = 12'h000;
  localparam logic [11:0] OFF_CONTROL      = 12'h004;
  localparam logic [11:0] OFF_FLOW         = 12'h008;
  localparam logic [11:0] OFF_LOCATION     = 12'h00C;
  localparam logic [11:0] OFF_REGION_START = 12'h010;
  localparam logic [11:0] OFF_REGION_END   = 12'h014;

  // field positions
  localparam int CTRL_EN_BIT       = 31;
  localparam int POS_WRAP_BIT      = 2;
  localparam int FLOW_STOP_BIT     = 0;
  localparam int FLOW_HALT_BIT     = 1;
  localparam int PAIR_LSB          = 3;
  localparam int WORD_LSB          = 2;

  // reset values
  localparam logic        CTRL_EN_RST  = 1'b0;
  localparam logic        WRAP_RST     = 1'b0;
  localparam logic        FLOW_STOP_RST = 1'b0;
  localparam logic        FLOW_HALT_RST = 1'b0;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  // one retired instruction as seen on the execution trace interface
  typedef struct packed {
    logic        valid;
    logic        branch;
    logic        excp;
    logic [31:0] src;
    logic [31:0] dst;
  } pftb_trace_t;

  // two-word packet written to the trace region
  typedef struct packed {
    logic [31:0] word0;
    logic [31:0] word1;
  } pftb_packet_t;

  // processor request towards the shared sram
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pftb_cpu_req_t;

  typedef enum logic [1:0] {
    PFTB_IDLE,
    PFTB_WORD0,
    PFTB_WORD1
  } pftb_wr_state_t;

endpackage

/* src/pftb_recorder.sv */
/*
 * Program-flow trace recorder with its shared sram. Non-sequential
 * pc changes become two-word packets written into a circular region of
 * the sram; the processor shares the same sram at lower priority.
 * Assumes the trace interface and processor port are synchronous to
 * ref_clk, and the processor holds a request until cpu_ack.
 * Assumes software keeps the region start below its end and the
 * threshold inside the region; neither is checked here.
 * The sram has no reset, so its contents outlive a system reset.
 */

module pftb_recorder #(
  parameter int          SRAM_WORDS    = 2048,
  parameter int          AW            = $clog2(SRAM_WORDS),
  parameter logic [31:0] LOCATION_ADDR = 32'h2000_0000
) (
  input  wire  logic                  ref_clk,     // system clock
  input  wire  logic                  sys_rst,     // sync reset, high
  input  wire  logic                  psel,        // apb select
  input  wire  logic                  penable,     // apb access phase
  input  wire  logic                  pwrite,      // apb direction
  input  wire  logic [31:0]           paddr,       // apb byte address
  input  wire  logic [31:0]           pwdata,      // apb write data
  output logic [31:0]                 prdata,      // apb read data
  output logic                        pready,      // apb ready
  output logic                        pslverr,     // apb unmapped
  input  wire  pftb_pkg::pftb_trace_t trc,         // execution trace
  input  wire  pftb_pkg::pftb_cpu_req_t cpu,       // processor request
  output logic [31:0]                 cpu_rdata,   // processor read data
  output logic                        cpu_ack,     // processor done
  output logic                        dbg_halt_req // halt request pulse
);

  localparam int PW = AW - 1;

  // register state
  logic          trace_en;
  logic          wrap;
  logic [PW-1:0] wr_pair;
  logic [PW-1:0] region_start;
  logic [PW-1:0] region_end;
  logic [PW-1:0] watermark;
  logic          stop_at_threshold;
  logic          halt_at_threshold;
  logic          en_prev;
  logic          start_flag;

  // packet path
  pftb_pkg::pftb_wr_state_t state;
  pftb_pkg::pftb_wr_state_t next_state;
  pftb_pkg::pftb_packet_t   pkt;

  logic [31:0] mem [SRAM_WORDS];

  // register map, byte offsets inside the window:
  //   0x000 position: pair pointer in [AW+1:3], wrap flag in bit 2
  //   0x004 control:  trace enable in bit 31, other bits read zero
  //   0x008 flow:     threshold pair in [AW+1:3], halt bit 1, stop bit 0
  //   0x00C location: sram base in the processor map, read only
  //   0x010 region start, pair aligned, first pair used
  //   0x014 region end, pair aligned, first pair not used
  // any other offset is refused with pslverr and reads as zero

  // apb decode
  wire         in_window  = paddr[31:pftb_pkg::REG_WIN_LSB] ==
                            pftb_pkg::REG_BASE_ADDR[31:pftb_pkg::REG_WIN_LSB];
  wire  [11:0] off        = paddr[11:0];
  wire         hit_pos    = in_window && off == pftb_pkg::OFF_POSITION;
  wire         hit_ctrl   = in_window && off == pftb_pkg::OFF_CONTROL;
  wire         hit_flow   = in_window && off == pftb_pkg::OFF_FLOW;
  wire         hit_loc    = in_window && off == pftb_pkg::OFF_LOCATION;
  wire         hit_rstart = in_window && off == pftb_pkg::OFF_REGION_START;
  wire         hit_rend   = in_window && off == pftb_pkg::OFF_REGION_END;
  wire         hit_any    = hit_pos | hit_ctrl | hit_flow | hit_loc |
                            hit_rstart | hit_rend;
  wire         apb_setup  = psel & ~penable;
  wire         apb_wr     = psel & penable & pready & pwrite & ~pslverr;
  wire         wr_pos     = apb_wr & hit_pos;
  wire         wr_ctrl    = apb_wr & hit_ctrl;
  wire         wr_flow    = apb_wr & hit_flow;
  wire         wr_rstart  = apb_wr & hit_rstart;
  wire         wr_rend    = apb_wr & hit_rend;

  // byte offset views of the pair-indexed pointers
  wire  [31:0] pos_view   = {{(32-PW-pftb_pkg::PAIR_LSB){1'b0}}, wr_pair,
                             wrap, 2'b00};
  wire  [31:0] flow_view  = {{(32-PW-pftb_pkg::PAIR_LSB){1'b0}}, watermark,
                             1'b0, halt_at_threshold, stop_at_threshold};
  wire  [31:0] ctrl_view  = {trace_en, 31'h0000_0000};
  wire  [31:0] rs_view    = {{(32-PW-pftb_pkg::PAIR_LSB){1'b0}},
                             region_start, 3'b000};
  wire  [31:0] re_view    = {{(32-PW-pftb_pkg::PAIR_LSB){1'b0}},
                             region_end, 3'b000};
  wire  [31:0] next_prdata = hit_pos    ? pos_view      :
                             hit_ctrl   ? ctrl_view     :
                             hit_flow   ? flow_view     :
                             hit_loc    ? LOCATION_ADDR :
                             hit_rstart ? rs_view       :
                             hit_rend   ? re_view       :
                             pftb_pkg::RDATA_RST;

  // trace event detection
  wire         flow_change = trc.valid & (trc.branch | trc.excp);
  wire         pkt_done    = state == pftb_pkg::PFTB_WORD1;
  wire         en_rise     = trace_en & ~en_prev;
  wire         start_mark  = start_flag | en_rise;

  // pointer advance inside the region
  wire [PW-1:0] pair_inc   = wr_pair + 1'b1;
  wire          at_end     = pair_inc == region_end;
  wire [PW-1:0] pair_adv   = at_end ? region_start : pair_inc;
  wire          thr_hit    = pkt_done && pair_adv == watermark;
  wire          auto_stop  = thr_hit & stop_at_threshold;
  wire          wrap_now   = pkt_done & at_end & ~auto_stop;

  // no event taken at the stop edge, so the stop packet is the last
  wire         accept      = flow_change & trace_en & ~auto_stop &
                             (state != pftb_pkg::PFTB_WORD0);

  // each pair p of the region holds one packet: word0 at byte 8*p with
  // the source address and bit 0 set on exception entry, word1 at
  // 8*p+4 with the destination and bit 0 set on the first packet after
  // tracing is enabled; a processor access waits at most two cycles per
  // packet, since events closer than two cycles apart are dropped

  // shared sram port: trace first, processor otherwise
  wire          trace_wr   = state != pftb_pkg::PFTB_IDLE;
  wire          cpu_go     = cpu.req & ~trace_wr & ~cpu_ack;
  wire [AW-1:0] cpu_word   = cpu.addr[AW+1:pftb_pkg::WORD_LSB];
  wire [AW-1:0] trace_word = {wr_pair, state == pftb_pkg::PFTB_WORD1};
  wire          mem_we     = trace_wr | (cpu_go & cpu.we);
  wire [AW-1:0] mem_addr   = trace_wr ? trace_word : cpu_word;
  wire [31:0]   trace_data = (state == pftb_pkg::PFTB_WORD1) ?
                             pkt.word1 : pkt.word0;
  wire [31:0]   mem_wdata  = trace_wr ? trace_data : cpu.wdata;

  // next state: a packet in flight takes exactly two cycles
  always_comb begin
    next_state = state;
    case (state)
      pftb_pkg::PFTB_IDLE: begin
        if (accept) begin
          next_state = pftb_pkg::PFTB_WORD0;
        end
      end
      pftb_pkg::PFTB_WORD0: begin
        next_state = pftb_pkg::PFTB_WORD1;
      end
      pftb_pkg::PFTB_WORD1: begin
        if (accept) begin
          next_state = pftb_pkg::PFTB_WORD0;
        end else begin
          next_state = pftb_pkg::PFTB_IDLE;
        end
      end
      default: begin
        next_state = pftb_pkg::PFTB_IDLE;
      end
    endcase
  end

  // apb answer: ready one cycle after setup, data and error registered
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_setup;
    end
  end

  // unmapped offsets are refused in the same beat as ready
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apb_setup & ~hit_any;
    end
  end

  // read data loaded at setup and held until the next setup
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= pftb_pkg::RDATA_RST;
    end else if (apb_setup) begin
      prdata <= pwrite ? pftb_pkg::RDATA_RST : next_prdata;
    end
  end

  // enable: software write wins over the automatic stop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      trace_en <= pftb_pkg::CTRL_EN_RST;
    end else if (wr_ctrl) begin
      trace_en <= pwdata[pftb_pkg::CTRL_EN_BIT];
    end else if (auto_stop) begin
      trace_en <= 1'b0;
    end
  end

  // delayed enable, used only to spot a fresh start of recording
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      en_prev <= pftb_pkg::CTRL_EN_RST;
    end else begin
      en_prev <= trace_en;
    end
  end

  // flow configuration: threshold and its two actions
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      watermark         <= '0;
      stop_at_threshold <= pftb_pkg::FLOW_STOP_RST;
      halt_at_threshold <= pftb_pkg::FLOW_HALT_RST;
    end else if (wr_flow) begin
      watermark         <= pwdata[PW+pftb_pkg::PAIR_LSB-1:
                                  pftb_pkg::PAIR_LSB];
      stop_at_threshold <= pwdata[pftb_pkg::FLOW_STOP_BIT];
      halt_at_threshold <= pwdata[pftb_pkg::FLOW_HALT_BIT];
    end
  end

  // region start: first pair the pointer returns to on a wrap
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      region_start <= '0;
    end else if (wr_rstart) begin
      region_start <= pwdata[PW+pftb_pkg::PAIR_LSB-1:pftb_pkg::PAIR_LSB];
    end
  end

  // zero end lets the region run up to the top of the sram
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      region_end <= '0;
    end else if (wr_rend) begin
      region_end <= pwdata[PW+pftb_pkg::PAIR_LSB-1:pftb_pkg::PAIR_LSB];
    end
  end

  // write pointer: a software value wins over the advance
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pair <= '0;
    end else if (wr_pos) begin
      wr_pair <= pwdata[PW+pftb_pkg::PAIR_LSB-1:pftb_pkg::PAIR_LSB];
    end else if (pkt_done) begin
      wr_pair <= pair_adv;
    end
  end

  // wrap flag: hardware set wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wrap <= pftb_pkg::WRAP_RST;
    end else if (wrap_now) begin
      wrap <= 1'b1;
    end else if (wr_pos) begin
      wrap <= pwdata[pftb_pkg::POS_WRAP_BIT];
    end
  end

  // packet sequencer: idle, then one cycle for each word
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= pftb_pkg::PFTB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // start mark: a fresh enable raises it, the packet that carries it
  // clears it; both in one cycle means the mark is already consumed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      start_flag <= 1'b0;
    end else if (accept) begin
      start_flag <= 1'b0;
    end else if (en_rise) begin
      start_flag <= 1'b1;
    end
  end

  // packet capture; first packet after enabling carries a start mark
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pkt <= '0;
    end else if (accept) begin
      pkt.word0 <= {trc.src[31:1], trc.excp};
      pkt.word1 <= {trc.dst[31:1], start_mark};
    end
  end

  // halt request pulses once per threshold crossing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dbg_halt_req <= 1'b0;
    end else begin
      dbg_halt_req <= thr_hit & halt_at_threshold;
    end
  end

  // sram array; no reset so contents survive for the debugger
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  // processor answer one cycle after service
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= cpu_go;
    end
  end

  // read data holds after the ack until the next processor read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cpu_rdata <= pftb_pkg::RDATA_RST;
    end else if (cpu_go & ~cpu.we) begin
      cpu_rdata <= mem[cpu_word];
    end
  end

endmodule

/* testbench/pftb_recorder_assertions.sv */
/*
 * Port-level checker of the trace recorder.
 * Assumes binding into pftb_recorder, one clock, sync high reset.
 */
module pftb_recorder_assertions (
  input wire logic                    ref_clk,      // system clock
  input wire logic                    sys_rst,      // sync reset, high
  input wire logic                    psel,         // apb select
  input wire logic                    penable,      // apb access phase
  input wire logic                    pwrite,       // apb direction
  input wire logic [31:0]             paddr,        // apb address
  input wire logic [31:0]             prdata,       // apb read data
  input wire logic                    pready,       // apb ready
  input wire logic                    pslverr,      // apb error
  input wire pftb_pkg::pftb_cpu_req_t cpu,          // processor request
  input wire logic                    cpu_ack,      // processor done
  input wire logic                    dbg_halt_req  // halt request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_outside: assert property (psel && !penable &&
      paddr[31:12] != 20'h41006 |=> pslverr)
    else $error("no error outside register window");
  a_err_data: assert property (pready && (pslverr || pwrite)
      |-> prdata == 32'h0000_0000)
    else $error("read data not zero on error or write");
  a_ack_pulse: assert property (cpu_ack |=> !cpu_ack)
    else $error("cpu_ack longer than one cycle");
  a_ack_cause: assert property (!cpu.req |=> !cpu_ack)
    else $error("cpu_ack without request");
  a_ack_bound: assert property (cpu.req && !cpu_ack
      |-> ##[1:12] cpu_ack)
    else $error("processor access never served");
  a_halt_pulse: assert property (dbg_halt_req |=> !dbg_halt_req)
    else $error("halt request longer than one cycle");
endmodule

/* testbench/pftb_core_model.sv */
/*
 * Processor core model: execution trace events and sram accesses.
 * Assumes its tasks are called from one bench process each.
 */
module pftb_core_model (
  input  wire logic              ref_clk,   // system clock
  input  wire logic              cpu_ack,   // request served
  input  wire logic [31:0]       cpu_rdata, // sram read data
  output pftb_pkg::pftb_trace_t  trc,       // execution trace
  output pftb_pkg::pftb_cpu_req_t cpu       // sram request
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    trc = '0;
    cpu = '0;
  end
  // one flow change, then idle so both words land
  task automatic flow(input logic ex, input logic [31:0] s, d);
    @(posedge ref_clk) trc <= {1'b1, ~ex, ex, s, d};
    @(posedge ref_clk) trc <= {1'b0, 2'b00, ~s, ~d};
    repeat (4) @(posedge ref_clk);
  endtask
  // released address and data flip so stale values never match
  task automatic access(input logic we, input logic [31:0] a, wd,
                        output logic [31:0] rd, output int n);
    n = 0;
    @(posedge ref_clk) cpu <= {1'b1, we, a, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (cpu_ack !== 1'b1);
    rd = cpu_rdata;
    cpu <= {1'b0, 1'b0, ~a, ~wd};
  endtask
endmodule

/* testbench/pftb_recorder_bench.sv */
/*
 * Self-checking bench of the trace recorder: apb tasks and core model.
 * Assumes the default sram size and location parameters.
 */
module pftb_recorder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] B     = pftb_pkg::REG_BASE_ADDR;
  localparam logic [31:0] A_POS = B + pftb_pkg::OFF_POSITION;
  localparam logic [31:0] A_CTL = B + pftb_pkg::OFF_CONTROL;
  localparam logic [31:0] A_FLW = B + pftb_pkg::OFF_FLOW;
  localparam logic [31:0] A_LOC = B + pftb_pkg::OFF_LOCATION;
  localparam logic [31:0] A_RS  = B + pftb_pkg::OFF_REGION_START;
  localparam logic [31:0] A_RE  = B + pftb_pkg::OFF_REGION_END;
  logic                    ref_clk, sys_rst, psel, penable, pwrite;
  logic                    pready, pslverr, cpu_ack, dbg_halt_req;
  logic [31:0]             paddr, pwdata, prdata, cpu_rdata, v;
  pftb_pkg::pftb_trace_t   trc;
  pftb_pkg::pftb_cpu_req_t cpu;
  int                      err_total = 0, n_tests = 0, cyc = 0;
  int                      halts = 0, n;

  pftb_recorder i_pftb_recorder (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trc(trc), .cpu(cpu), .cpu_rdata(cpu_rdata),
    .cpu_ack(cpu_ack), .dbg_halt_req(dbg_halt_req));
  pftb_core_model i_pftb_core_model (.ref_clk(ref_clk),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .trc(trc), .cpu(cpu));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (dbg_halt_req === 1'b1) halts <= halts + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, wd,
                     output logic [31:0] rd, output logic er);
    @(posedge ref_clk) begin
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
    end
    @(posedge ref_clk) penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic e;
    apb(1'b1, a, d, v, e);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, e,
                    input logic ee);
    logic [31:0] d;
    logic        er;
    apb(1'b0, a, 32'h0, d, er);
    chk(nm, e, d);
    chk({nm, "_err"}, {31'h0, ee}, {31'h0, er});
  endtask
  task automatic mem(input string nm, input logic [31:0] a, e);
    i_pftb_core_model.access(1'b0, a, 32'h0, v, n);
    chk(nm, e, v);
  endtask

  initial begin
    sys_rst = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd("location", A_LOC, 32'h2000_0000, 1'b0);
    rd("control", A_CTL, 32'h0, 1'b0);
    rd("position", A_POS, 32'h0, 1'b0);
    rd("flow", A_FLW, 32'h0, 1'b0);
    rd("hole", B + 32'h18, 32'h0, 1'b1);
    rd("outside", B + 32'h1000, 32'h0, 1'b1);
    wr(A_LOC, 32'h0);
    rd("loc_ro", A_LOC, 32'h2000_0000, 1'b0);
    $display("test registers done");
    wr(A_RS, 32'h100);
    wr(A_RE, 32'h120);
    rd("reg_start", A_RS, 32'h100, 1'b0);
    rd("reg_end", A_RE, 32'h120, 1'b0);
    wr(A_POS, 32'h100);
    i_pftb_core_model.access(1'b1, 32'h120, 32'hA5A5_A5A5, v, n);
    wr(A_CTL, 32'h8000_0000);
    i_pftb_core_model.flow(1'b0, 32'h1234, 32'h5678);
    mem("br_w0", 32'h100, 32'h1234);
    mem("br_w1", 32'h104, 32'h5679);
    i_pftb_core_model.flow(1'b1, 32'hAB00, 32'hCD00);
    mem("ex_w0", 32'h108, 32'hAB01);
    mem("ex_w1", 32'h10C, 32'hCD00);
    rd("pos_two", A_POS, 32'h110, 1'b0);
    wr(A_CTL, 32'h0);
    i_pftb_core_model.flow(1'b0, 32'h40, 32'h80);
    rd("pos_off", A_POS, 32'h110, 1'b0);
    $display("test packets done");
    wr(A_CTL, 32'h8000_0000);
    fork
      i_pftb_core_model.flow(1'b0, 32'h10, 32'h20);
      begin
        @(posedge ref_clk);
        i_pftb_core_model.access(1'b0, 32'h120, 32'h0, v, n);
      end
    join
    chk("stall", 32'h1, {31'h0, n > 2});
    chk("shared", 32'hA5A5_A5A5, v);
    i_pftb_core_model.flow(1'b0, 32'h30, 32'h50);
    rd("pos_wrap", A_POS, 32'h104, 1'b0);
    mem("outside_region", 32'h120, 32'hA5A5_A5A5);
    mem("restart_w1", 32'h114, 32'h21);
    $display("test wrap done");
    wr(A_FLW, 32'h113);
    i_pftb_core_model.flow(1'b0, 32'h60, 32'h70);
    i_pftb_core_model.flow(1'b0, 32'h62, 32'h72);
    rd("ctl_stop", A_CTL, 32'h0, 1'b0);
    chk("halts", 32'h1, halts);
    i_pftb_core_model.flow(1'b0, 32'h64, 32'h74);
    rd("pos_stop", A_POS, 32'h114, 1'b0);
    mem("over_w0", 32'h100, 32'h60);
    mem("over_w1", 32'h104, 32'h70);
    mem("stop_keep", 32'h110, 32'h10);
    $display("test threshold done");
    close_out();
  end
endmodule

bind pftb_recorder pftb_recorder_assertions i_pftb_recorder_assertions (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu(cpu), .cpu_ack(cpu_ack),
  .dbg_halt_req(dbg_halt_req));
